// ===== hw/fdcnd_defs.vh
// constants for the non-data command decoder: register map, field
// positions, command classes, reset values and timing
// assumes a 200 MHz core clock
`ifndef FDCND_DEFS_VH
`define FDCND_DEFS_VH

// bus register byte offsets
`define FDCND_REG_DATA      8'h00
`define FDCND_REG_MSTAT     8'h04
`define FDCND_REG_IRQ_STAT  8'h08
`define FDCND_REG_IRQ_MASK  8'h0c

// main status bits
`define FDCND_MS_ACCEPT     0
`define FDCND_MS_RESULT     1
`define FDCND_MS_BUSY       2
`define FDCND_MS_SEEKING    3
`define FDCND_MS_LOCK       4

// interrupt event bits
`define FDCND_IRQ_SEEK      0
`define FDCND_IRQ_RESULT    1
`define FDCND_IRQ_INVALID   2
`define FDCND_IRQ_W         3

// operation codes
`define FDCND_OP_SPECIFY    8'h03
`define FDCND_OP_SDS        8'h04
`define FDCND_OP_RECAL      8'h07
`define FDCND_OP_SIS        8'h08
`define FDCND_OP_DUMP       8'h0e
`define FDCND_OP_SEEK       8'h0f
`define FDCND_OP_RELSEEK    8'h8f
`define FDCND_OP_VERSION    8'h10
`define FDCND_OP_PERP       8'h12
`define FDCND_OP_CONFIG     8'h13
`define FDCND_OP_LOCK       8'h14
`define FDCND_RELSEEK_MASK  8'hbf
`define FDCND_LOCK_MASK     8'h7f

// command classes
`define FDCND_C_INVALID     4'h0
`define FDCND_C_SPECIFY     4'h1
`define FDCND_C_SDS         4'h2
`define FDCND_C_RECAL       4'h3
`define FDCND_C_SIS         4'h4
`define FDCND_C_DUMP        4'h5
`define FDCND_C_SEEK        4'h6
`define FDCND_C_RELSEEK     4'h7
`define FDCND_C_VERSION     4'h8
`define FDCND_C_PERP        4'h9
`define FDCND_C_CONFIG      4'ha
`define FDCND_C_LOCK        4'hb

// result values
`define FDCND_ST0_INVALID   8'h80
`define FDCND_ST0_SEEK_END  8'h20
`define FDCND_DUMP_LEN      4'ha

// reset values of stored settings
`define FDCND_RST_CONFIG    8'h20
`define FDCND_RST_PRECOMP_START_TRACK    8'h00
`define FDCND_RST_EOT       8'h00

// timing: one step-rate unit and the core clock period
`define FDCND_STEP_UNIT_NS  1000000
`define FDCND_CLK_NS        5

`endif

// ===== hw/fdcnd_stepper.v
// head stepper: walks one drive's head position toward a target
// one step per interval; assumes start is a one-cycle pulse while idle
`timescale 1ns/1ps
`default_nettype none

module fdcnd_stepper (
	// clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// command side
	input  wire        start,
	input  wire [7:0]  start_pos,
	input  wire [7:0]  target,
	input  wire [23:0] interval,
	// drive side
	output reg         step_pulse,
	output reg         step_dir,
	output reg  [7:0]  pos,
	output reg         busy,
	output reg         done
);

	reg [7:0]  tgt_reg;
	reg [23:0] cnt_reg;

	// interval timer and position walk
	always @(posedge aclk) begin
		if (!aresetn) begin
			step_pulse <= 1'b0;
			step_dir   <= 1'b0;
			pos        <= 8'h00;
			busy       <= 1'b0;
			done       <= 1'b0;
			tgt_reg    <= 8'h00;
			cnt_reg    <= 24'h000000;
		end else begin
			step_pulse <= 1'b0;
			done       <= 1'b0;
			if (start && !busy) begin
				busy    <= 1'b1;
				pos     <= start_pos;
				tgt_reg <= target;
				cnt_reg <= interval;
			end else if (busy) begin
				if (cnt_reg > 24'h000001) begin
					cnt_reg <= cnt_reg - 24'h000001;
				end else if (pos == tgt_reg) begin
					busy <= 1'b0; // arrived
					done <= 1'b1;
				end else begin
					step_pulse <= 1'b1;
					step_dir   <= (tgt_reg > pos);
					pos        <= (tgt_reg > pos) ? pos + 8'h01 : pos - 8'h01;
					cnt_reg    <= interval;
				end
			end
		end
	end

endmodule // fdcnd_stepper

`default_nettype wire

// ===== hw/fdcnd_decoder.v
// non-data command decoder: command bytes arrive over AXI4-Lite,
// results are read back from the same data register
// assumes drive status pins are asynchronous to aclk
//
// Summary of operation
// - Recalibrate 07h plus drive byte retracts that head to track zero, no result.
// - Seek 0Fh plus head/drive byte plus cylinder steps head to that cylinder.
// - Relative seek steps given track count in or out per opcode bit 6.
// - Dump 0Eh returns four cylinders, step/unload, load/non-DMA, end-of-track bytes.
// - Dump bytes eight to ten: lock/perpendicular/gap, config settings, precomp track.
// - Sense interrupt 08h returns status zero then cylinder reached by seek.
// - Sense drive status 04h plus head/drive byte returns status byte three.
// - Undefined opcode is a no-op returning single status byte 80h.
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "fdcnd_defs.vh"

module fdcnd_decoder #(
	parameter        ADDR_W        = 8,
	parameter [23:0] STEP_UNIT_CYC = `FDCND_STEP_UNIT_NS / `FDCND_CLK_NS,
	parameter [7:0]  VERSION_CODE  = 8'h5a // arbitrary value
) (
	// clock and reset
	input  wire              aclk,
	input  wire              aresetn,
	// axi4-lite write
	input  wire [ADDR_W-1:0] s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output wire              s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output wire              s_axi_wready,
	output reg  [1:0]        s_axi_bresp,
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	// axi4-lite read
	input  wire [ADDR_W-1:0] s_axi_araddr,
	input  wire              s_axi_arvalid,
	output wire              s_axi_arready,
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready,
	// drive interface
	input  wire [3:0]        drv_track0,
	input  wire [3:0]        drv_wprot,
	input  wire [3:0]        drv_ready,
	output wire              step_pulse,
	output wire              step_dir,
	output reg  [1:0]        drive_sel,
	output reg               head_select,
	// interrupt
	output wire              irq
);

	localparam [4:0] ST_IDLE   = 5'h01;
	localparam [4:0] ST_PARAM  = 5'h02;
	localparam [4:0] ST_EXEC   = 5'h04;
	localparam [4:0] ST_SEEK   = 5'h08;
	localparam [4:0] ST_RESULT = 5'h10;

	// opcode to class
	function [3:0] op_class;
		input [7:0] op;
		begin
			if (op == `FDCND_OP_SPECIFY) op_class = `FDCND_C_SPECIFY;
			else if (op == `FDCND_OP_SDS) op_class = `FDCND_C_SDS;
			else if (op == `FDCND_OP_RECAL) op_class = `FDCND_C_RECAL;
			else if (op == `FDCND_OP_SIS) op_class = `FDCND_C_SIS;
			else if (op == `FDCND_OP_DUMP) op_class = `FDCND_C_DUMP;
			else if (op == `FDCND_OP_SEEK) op_class = `FDCND_C_SEEK;
			else if ((op & `FDCND_RELSEEK_MASK) == `FDCND_OP_RELSEEK) op_class = `FDCND_C_RELSEEK;
			else if (op == `FDCND_OP_VERSION) op_class = `FDCND_C_VERSION;
			else if (op == `FDCND_OP_PERP) op_class = `FDCND_C_PERP;
			else if (op == `FDCND_OP_CONFIG) op_class = `FDCND_C_CONFIG;
			else if ((op & `FDCND_LOCK_MASK) == `FDCND_OP_LOCK) op_class = `FDCND_C_LOCK;
			else op_class = `FDCND_C_INVALID;
		end
	endfunction

	// class to number of parameter bytes
	function [1:0] param_len;
		input [3:0] cls;
		begin
			case (cls)
				`FDCND_C_SPECIFY, `FDCND_C_SEEK, `FDCND_C_RELSEEK: param_len = 2'd2;
				`FDCND_C_SDS, `FDCND_C_RECAL, `FDCND_C_PERP:       param_len = 2'd1;
				`FDCND_C_CONFIG:                                   param_len = 2'd3;
				default:                                           param_len = 2'd0;
			endcase
		end
	endfunction

	reg  [4:0]  state_reg;
	reg  [7:0]  cmd_reg;
	reg  [3:0]  cls_reg;
	reg  [1:0]  pidx_reg;
	reg  [7:0]  par_reg [0:2];
	reg  [3:0]  res_len_reg;
	reg  [3:0]  res_ptr_reg;
	reg  [7:0]  pcn_reg [0:3];
	reg  [3:0]  srt_reg, hut_reg;
	reg  [6:0]  hlt_reg;
	reg         nd_reg;
	reg  [7:0]  cfg_reg;
	reg  [7:0]  precomp_start_track_reg;
	reg         lock_reg;
	reg  [3:0]  perp_dc_reg;
	reg         gap_reg, wg_reg;
	reg         seek_pend_reg, sis_ok_reg;
	reg  [1:0]  seek_drv_reg;
	reg         seek_head_reg;
	reg  [11:0] sync1_reg, sync2_reg;
	reg         aw_held_reg, w_held_reg;
	reg  [ADDR_W-1:0] awaddr_reg;
	reg  [7:0]  wdata_reg;
	reg         wstrb0_reg;
	reg  [`FDCND_IRQ_W-1:0] irq_stat_reg, irq_mask_reg;

	wire        wr_fire  = aw_held_reg && w_held_reg && !s_axi_bvalid;
	wire        rd_fire  = s_axi_arvalid && s_axi_arready;
	wire [7:0]  wr_addr  = awaddr_reg[7:0] & 8'hfc; // map lives in the low byte
	wire [7:0]  rd_addr  = s_axi_araddr[7:0] & 8'hfc;
	wire        push     = wr_fire && wstrb0_reg && (wr_addr == `FDCND_REG_DATA);
	wire        pop      = rd_fire && (rd_addr == `FDCND_REG_DATA) && (state_reg == ST_RESULT);
	wire [3:0]  push_cls = op_class(wdata_reg);
	wire [1:0]  hd_drv   = par_reg[0][1:0];
	wire [7:0]  cur_pcn  = pcn_reg[hd_drv];
	wire [8:0]  rel_sum  = {1'b0, cur_pcn} + {1'b0, par_reg[1]};
	wire [3:0]  trk0_s   = sync2_reg[3:0];
	wire [3:0]  wprot_s  = sync2_reg[7:4];
	wire [3:0]  ready_s  = sync2_reg[11:8];
	wire [7:0]  stp_pos;
	wire        stp_busy, stp_done;
	reg  [7:0]  stp_target;
	reg  [7:0]  res_byte;

	// two-flop synchroniser for drive status pins
	always @(posedge aclk) begin
		if (!aresetn) begin
			sync1_reg <= 12'h000;
			sync2_reg <= 12'h000;
		end else begin
			sync1_reg <= {drv_ready, drv_wprot, drv_track0};
			sync2_reg <= sync1_reg;
		end
	end

	// seek target per command
	always @* begin
		stp_target = par_reg[1];
		if (cls_reg == `FDCND_C_RECAL)
			stp_target = 8'h00;
		else if (cls_reg == `FDCND_C_RELSEEK) begin
			if (cmd_reg[6])
				stp_target = rel_sum[8] ? 8'hff : rel_sum[7:0];
			else
				stp_target = (cur_pcn > par_reg[1]) ? cur_pcn - par_reg[1] : 8'h00;
		end
	end

	fdcnd_stepper u_stepper (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.start      (state_reg == ST_EXEC && (cls_reg == `FDCND_C_RECAL || cls_reg == `FDCND_C_SEEK ||
		             cls_reg == `FDCND_C_RELSEEK)),
		.start_pos  (cur_pcn),
		.target     (stp_target),
		.interval   (STEP_UNIT_CYC * {19'h00000, 5'h10 - {1'b0, srt_reg}}), // 16 - rate, no 4-bit wrap at rate 0
		.step_pulse (step_pulse),
		.step_dir   (step_dir),
		.pos        (stp_pos),
		.busy       (stp_busy),
		.done       (stp_done)
	);

	// result byte selected by read pointer
	always @* begin
		res_byte = `FDCND_ST0_INVALID;
		case (cls_reg)
			`FDCND_C_SDS:
				res_byte = {1'b0, wprot_s[hd_drv], ready_s[hd_drv], trk0_s[hd_drv],
				            1'b0, par_reg[0][2:0]};
			`FDCND_C_SIS:
				if (res_ptr_reg == 4'h0)
					res_byte = sis_ok_reg ? (`FDCND_ST0_SEEK_END | {5'h00, seek_head_reg, seek_drv_reg})
					                      : `FDCND_ST0_INVALID;
				else
					res_byte = pcn_reg[seek_drv_reg];
			`FDCND_C_DUMP:
				case (res_ptr_reg)
					4'h0, 4'h1, 4'h2, 4'h3: res_byte = pcn_reg[res_ptr_reg[1:0]];
					4'h4: res_byte = {srt_reg, hut_reg};
					4'h5: res_byte = {hlt_reg, nd_reg};
					4'h6: res_byte = `FDCND_RST_EOT;
					4'h7: res_byte = {lock_reg, 1'b0, perp_dc_reg, gap_reg, wg_reg};
					4'h8: res_byte = {1'b0, cfg_reg[6:0]};
					default: res_byte = precomp_start_track_reg;
				endcase
			`FDCND_C_VERSION: res_byte = VERSION_CODE;
			`FDCND_C_LOCK: res_byte = {3'h0, lock_reg, 4'h0};
			default: res_byte = `FDCND_ST0_INVALID;
		endcase
	end

	// command phase sequencer and stored settings
	always @(posedge aclk) begin : seq
		integer i;
		if (!aresetn) begin
			state_reg     <= ST_IDLE;
			cmd_reg       <= 8'h00;
			cls_reg       <= `FDCND_C_INVALID;
			pidx_reg      <= 2'd0;
			res_len_reg   <= 4'h0;
			res_ptr_reg   <= 4'h0;
			srt_reg       <= 4'h0;
			hut_reg       <= 4'h0;
			hlt_reg       <= 7'h00;
			nd_reg        <= 1'b0;
			cfg_reg       <= `FDCND_RST_CONFIG;
			precomp_start_track_reg    <= `FDCND_RST_PRECOMP_START_TRACK;
			lock_reg      <= 1'b0;
			perp_dc_reg   <= 4'h0;
			gap_reg       <= 1'b0;
			wg_reg        <= 1'b0;
			seek_pend_reg <= 1'b0;
			sis_ok_reg    <= 1'b0;
			seek_drv_reg  <= 2'd0;
			seek_head_reg <= 1'b0;
			drive_sel     <= 2'd0;
			head_select   <= 1'b0;
			for (i = 0; i < 4; i = i + 1) begin
				pcn_reg[i] <= 8'h00;
			end
			for (i = 0; i < 3; i = i + 1) begin
				par_reg[i] <= 8'h00;
			end
		end else begin
			case (state_reg)
				ST_IDLE: if (push) begin
					cmd_reg  <= wdata_reg;
					cls_reg  <= push_cls;
					pidx_reg <= 2'd0;
					state_reg <= (param_len(push_cls) == 2'd0) ? ST_EXEC : ST_PARAM;
				end
				ST_PARAM: if (push) begin
					par_reg[pidx_reg] <= wdata_reg;
					pidx_reg <= pidx_reg + 2'd1;
					if (pidx_reg + 2'd1 == param_len(cls_reg))
						state_reg <= ST_EXEC;
				end
				ST_EXEC: begin
					res_ptr_reg <= 4'h0;
					res_len_reg <= 4'h1;
					state_reg   <= ST_RESULT;
					case (cls_reg)
						`FDCND_C_SPECIFY: begin
							{srt_reg, hut_reg} <= par_reg[0];
							{hlt_reg, nd_reg}  <= par_reg[1];
							state_reg <= ST_IDLE;
						end
						`FDCND_C_RECAL, `FDCND_C_SEEK, `FDCND_C_RELSEEK: begin
							drive_sel   <= hd_drv;
							head_select <= par_reg[0][2] && cls_reg != `FDCND_C_RECAL;
							state_reg   <= ST_SEEK;
						end
						`FDCND_C_SIS: begin
							sis_ok_reg    <= seek_pend_reg;
							seek_pend_reg <= 1'b0;
							res_len_reg   <= seek_pend_reg ? 4'h2 : 4'h1;
						end
						`FDCND_C_DUMP: res_len_reg <= `FDCND_DUMP_LEN;
						`FDCND_C_PERP: begin
							if (par_reg[0][7])
								perp_dc_reg <= par_reg[0][5:2];
							{gap_reg, wg_reg} <= par_reg[0][1:0];
							state_reg <= ST_IDLE;
						end
						`FDCND_C_CONFIG: begin
							cfg_reg    <= par_reg[1];
							precomp_start_track_reg <= par_reg[2];
							state_reg  <= ST_IDLE;
						end
						`FDCND_C_LOCK: lock_reg <= cmd_reg[7];
						default: res_len_reg <= 4'h1;
					endcase
				end
				ST_SEEK: if (stp_done) begin
					pcn_reg[drive_sel] <= stp_pos;
					seek_pend_reg <= 1'b1;
					seek_drv_reg  <= drive_sel;
					seek_head_reg <= head_select;
					state_reg     <= ST_IDLE;
				end
				ST_RESULT: if (pop) begin
					res_ptr_reg <= res_ptr_reg + 4'h1;
					if (res_ptr_reg + 4'h1 == res_len_reg)
						state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// bus slave: address and data taken in either order
	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg  <= 1'b0;
			w_held_reg   <= 1'b0;
			awaddr_reg   <= {ADDR_W{1'b0}};
			wdata_reg    <= 8'h00;
			wstrb0_reg   <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= 2'b00;
			s_axi_rdata  <= 32'h00000000;
			irq_mask_reg <= {`FDCND_IRQ_W{1'b0}};
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata[7:0];
				wstrb0_reg <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				aw_held_reg  <= 1'b0;
				w_held_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_addr > `FDCND_REG_IRQ_MASK) ? 2'b10 : 2'b00;
				if (wr_addr == `FDCND_REG_IRQ_MASK && wstrb0_reg)
					irq_mask_reg <= wdata_reg[`FDCND_IRQ_W-1:0];
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'b00;
				case (rd_addr)
					`FDCND_REG_DATA:     s_axi_rdata <= {24'h000000, pop ? res_byte : 8'h00};
					`FDCND_REG_MSTAT:    s_axi_rdata <= {27'h0, lock_reg, stp_busy, state_reg != ST_IDLE &&
					                     state_reg != ST_PARAM, state_reg == ST_RESULT, state_reg == ST_IDLE ||
					                     state_reg == ST_PARAM};
					`FDCND_REG_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat_reg};
					`FDCND_REG_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask_reg};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= 2'b10;
					end
				endcase
			end else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// sticky events, write one to clear, set wins over clear
	wire [`FDCND_IRQ_W-1:0] irq_set = {state_reg == ST_EXEC && cls_reg == `FDCND_C_INVALID,
	                                   state_reg == ST_EXEC && state_reg != ST_SEEK,
	                                   state_reg == ST_SEEK && stp_done};
	wire [`FDCND_IRQ_W-1:0] irq_clr = (wr_fire && wstrb0_reg && wr_addr == `FDCND_REG_IRQ_STAT) ?
	                                  wdata_reg[`FDCND_IRQ_W-1:0] : {`FDCND_IRQ_W{1'b0}};

	// result event only for commands that have a result phase
	wire res_evt_ok = !(cls_reg == `FDCND_C_SPECIFY || cls_reg == `FDCND_C_PERP || cls_reg == `FDCND_C_CONFIG ||
	                    cls_reg == `FDCND_C_RECAL || cls_reg == `FDCND_C_SEEK || cls_reg == `FDCND_C_RELSEEK);

	// status update
	always @(posedge aclk) begin
		if (!aresetn)
			irq_stat_reg <= {`FDCND_IRQ_W{1'b0}};
		else
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | (irq_set & {1'b1, res_evt_ok, 1'b1});
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);

endmodule // fdcnd_decoder

`default_nettype wire

// ===== tb/fdcnd_decoder_assertions.sv
// checker for the decoder's bus handshakes and head step outputs
// assumes it is bound into every fdcnd_decoder instance
`timescale 1ns/1ps
`default_nettype none
module fdcnd_decoder_chk #(
	parameter ADDR_W = 8
) (
	// clock and reset
	input wire logic              aclk,
	input wire logic              aresetn,
	// bus
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	// drive side
	input wire logic              step_pulse,
	input wire logic              step_dir,
	input wire logic              irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// write answer two cycles after both halves are taken, read answer one cycle
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write answer late");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	// answers stand until taken
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rresp, s_axi_rdata}))
		else $error("read answer dropped");
	rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	// holes in the map answer with an error and zero data
	unmapped_rd_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h03 |=>
		s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	// registers are one byte wide
	upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	// one pulse per step, direction held between steps
	step_pulse_a: assert property (step_pulse |=> !step_pulse)
		else $error("step pulse too long");
	step_dir_a: assert property (step_pulse |=> $stable(step_dir)[*3])
		else $error("step direction changed mid seek");
	// main scenarios
	step_c: cover property (step_pulse && step_dir);
	invalid_c: cover property (s_axi_rvalid && s_axi_rdata == 32'h80);
	irq_c: cover property ($rose(irq));
endmodule // fdcnd_decoder_chk
bind fdcnd_decoder fdcnd_decoder_chk #(.ADDR_W(ADDR_W)) chk_i (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .step_pulse(step_pulse),
	.step_dir(step_dir), .irq(irq));
`default_nettype wire

// ===== tb/fdcnd_host.sv
// host model: writes command bytes and reads results over the bus
// assumes wr and rd are called from one process, one at a time
`timescale 1ns/1ps
`default_nettype none
module fdcnd_host (
	// clock
	input  wire logic   aclk,
	// write channels
	output logic [7:0]  awaddr,
	output logic        awvalid,
	input  wire logic   awready,
	output logic [31:0] wdata,
	output logic [3:0]  wstrb,
	output logic        wvalid,
	input  wire logic   wready,
	input  wire logic   bvalid,
	output logic        bready,
	// read channels
	output logic [7:0]  araddr,
	output logic        arvalid,
	input  wire logic   arready,
	input  wire logic   rvalid,
	output logic        rready
);
	// bus idle at time zero
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end
	// one write, each half held until taken, answer awaited
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= {24'h0, d};
		wstrb   <= 4'hf;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bready && bvalid) bready <= 1'b0;
		end while (awvalid || wvalid || bready);
		// released lines must not keep the old value
		awaddr <= ~a;
		wdata  <= ~wdata;
	endtask
	// one read, address held until taken, data awaited
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rready && rvalid) rready <= 1'b0;
		end while (arvalid || rready);
		araddr <= ~a;
	endtask
endmodule // fdcnd_host
`default_nettype wire

// ===== tb/test_fdcnd_decoder.sv
// self-checking bench for the non-data command decoder
// assumes the host model drives the bus and the checker is bound in
`timescale 1ns/1ps
`default_nettype none
module test_fdcnd_decoder;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr, araddr, c, n, m, c2, sp1, sp2, cfg, pre, pb;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb, drv_track0, drv_wprot, drv_ready;
	logic [1:0]  bresp, rresp, drive_sel, d;
	logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic        step_pulse, step_dir, head_select, irq, h, exp_dir;
	logic [8:0]  steps = 9'h0;
	logic [7:0]  inv [4] = '{8'h00, 8'h1f, 8'hff, 8'h40};
	logic [33:0] q [$];
	int          error_cnt = 0;
	int          checked = 0;
	int          cyc = 0;

	fdcnd_decoder #(.STEP_UNIT_CYC(24'd4), .VERSION_CODE(8'h3c)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .drv_track0(drv_track0), .drv_wprot(drv_wprot), .drv_ready(drv_ready),
		.step_pulse(step_pulse), .step_dir(step_dir), .drive_sel(drive_sel), .head_select(head_select), .irq(irq));
	fdcnd_host host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready));

	// 200 MHz clock
	initial forever #2.5 aclk = ~aclk;

	task automatic chk(input string nm, input logic [33:0] got, input logic [33:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic print_verdict;
		if (error_cnt == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// note an expected register read, then read it
	task automatic rdq(input logic [7:0] a, input logic [33:0] e);
		q.push_back(e);
		host.rd(a);
	endtask
	task automatic w(input logic [7:0] b);
		host.wr(8'h00, b);
	endtask
	// pop one result byte once the command has settled
	task automatic res(input logic [7:0] e);
		repeat (3) @(posedge aclk);
		rdq(8'h00, {26'h0, e});
	endtask
	// head move: count steps in the expected direction until the seek event
	task automatic mv(input logic [7:0] op, input logic [7:0] hd, input logic [7:0] cy, input logic dir, input logic [8:0] ns);
		steps   <= 9'h0;
		exp_dir <= dir;
		w(op);
		w(hd);
		if (op != 8'h07) w(cy);
		while (irq !== 1'b1) @(posedge aclk);
		host.wr(8'h08, 8'h01);
		chk("steps", steps, ns);
	endtask

	// step counter and read monitor
	always @(posedge aclk) begin
		if (step_pulse === 1'b1 && step_dir === exp_dir) steps <= steps + 9'h1;
		if (rvalid === 1'b1 && rready === 1'b1) chk("read", {rresp, rdata}, q.size() > 0 ? q.pop_front() : '1);
		if (bvalid === 1'b1 && bready === 1'b1) chk("bresp", bresp, 2'b00); // every bench write hits the map
	end
	// hang guard
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			error_cnt++;
			print_verdict();
		end
	end

	initial begin
		void'($urandom(32'hf358));
		{drv_track0, drv_wprot, drv_ready} <= 12'($urandom);
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rdq(8'h04, 34'h1);
		rdq(8'h0c, 34'h0);
		rdq(8'h40, {2'b10, 32'h0});
		w(8'h08);
		res(8'h80);
		inv[3] = 8'h40 | 8'($urandom & 15);
		foreach (inv[i]) begin
			w(inv[i]);
			res(8'h80);
		end
		chk("irq", irq, 0);
		host.wr(8'h0c, 8'h04);
		repeat (2) @(posedge aclk);
		chk("irq", irq, 1);
		host.wr(8'h08, 8'h04);
		repeat (2) @(posedge aclk);
		chk("irq", irq, 0);
		host.wr(8'h0c, 8'h01);
		rdq(8'h0c, 34'h1);
		host.wr(8'h08, 8'h07);
		{sp1, sp2, cfg, pre, pb, d, h} = {$urandom, 11'($urandom)};
		cfg = cfg & 8'h7f;
		pb = pb | 8'h80;
		c = 8'h1 + 8'($urandom & 15);
		n = 8'h1 + 8'($urandom & 7);
		m = 8'h1 + 8'($urandom & 3);
		c2 = 8'h1 + 8'($urandom & 15);
		w(8'h03);
		w(sp1);
		w(sp2);
		w(8'h13);
		w(8'h00);
		w(cfg);
		w(pre);
		w(8'h12);
		w(pb);
		mv(8'h0f, 8'h05, c, 1'b1, 9'(c));
		chk("sel", {drive_sel, head_select}, 3'b011);
		w(8'h08);
		res(8'h25);
		res(c);
		mv(8'hcf, 8'h01, n, 1'b1, 9'(n));
		mv(8'h8f, 8'h01, m, 1'b0, 9'(m));
		mv(8'h07, 8'h01, 8'h0, 1'b0, 9'(c + n - m));
		w(8'h08);
		res(8'h21);
		res(8'h00);
		mv(8'h0f, 8'h02, c2, 1'b1, 9'(c2));
		w(8'h94);
		res(8'h10);
		w(8'h0e);
		foreach (inv[i]) res(i == 2 ? c2 : 8'h00);
		res(sp1);
		res(sp2);
		res(8'h00);
		res({2'b10, pb[5:0]});
		res(cfg);
		res(pre);
		w(8'h14);
		res(8'h00);
		w(8'h10);
		res(8'h3c);
		w(8'h04);
		w({5'h0, h, d});
		res({1'b0, drv_wprot[d], drv_ready[d], drv_track0[d], 1'b0, h, d});
		repeat (4) @(posedge aclk);
		print_verdict();
	end
endmodule // test_fdcnd_decoder
`default_nettype wire
